// >>> inc/swl_pkg.sv
// constants, field layout and types of the stop-mode wake logic
package swl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_POR_MAX_US = 10000; // longest por-class wake delay
  localparam int unsigned T_SHORT_US = 2500; // delay once oscillation is seen
  localparam int unsigned POR_CYC = T_POR_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SHORT_CYC = T_SHORT_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W = 20;
  localparam int AW = 16;
  localparam int DW = 32;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_SRC = 14'h0F0B;
  localparam logic [13:0] IDX_P2CW = 14'h0F0C;
  localparam logic [13:0] IDX_COMBO = 14'h0F0D;
  localparam logic [13:0] IDX_P3CW = 14'h0F0E;
  localparam logic [13:0] IDX_ROUTE = 14'h0F10;
  localparam logic [13:0] IDX_P2DAT = 14'h0002;
  localparam logic [13:0] IDX_P3DAT = 14'h0003;
  localparam logic [13:0] IDX_P2DIR = 14'h00F6;
  localparam logic [13:0] IDX_P3DIR = 14'h00F7;
  // stop_recovery_control fields
  localparam int SRC_FLAG = 7;
  localparam int SRC_LVL = 6;
  localparam int SRC_DLY = 5;
  localparam int SRC_MODE_HI = 4;
  localparam int SRC_MODE_LO = 2;
  localparam int SRC_SHORT = 1;
  localparam int SRC_DIV = 0;
  localparam logic [7:0] SRC_RST = 8'h20;
  localparam logic [7:0] SRC_WMASK = 8'h7F; // flag bit is not writable
  // combo_wake_select and wake_route_status fields
  localparam int COMBO_LVL = 3;
  localparam int RT_EN = 4;
  localparam logic [1:0] ST_NONE = 2'h0;
  localparam logic [1:0] ST_READ = 2'h1;
  localparam logic [1:0] ST_WRITE = 2'h2;
  // pin group masks over {port3[3:0], port2[7:0]}
  localparam logic [11:0] M_P31 = 12'h200;
  localparam logic [11:0] M_P32 = 12'h400;
  localparam logic [11:0] M_P33 = 12'h800;
  localparam logic [11:0] M_P2LO = 12'h00F;
  localparam logic [11:0] M_P2HI = 12'h0F0;
  localparam logic [11:0] M_P2ALL = 12'h0FF;
  typedef enum logic [2:0] {
    MODE_NONE, MODE_RSV, MODE_P31, MODE_P32, MODE_P33, MODE_P2LO, MODE_P2HI, MODE_P2ALL
  } swl_mode_e;
  typedef enum logic [1:0] {ST_RUN, ST_STOPPED, ST_RECOVER} swl_state_e;
endpackage

// >>> inc/swl_pins_if.sv
// synchronised pins, masks and selections shared with the level source logic
`timescale 1ns/1ps
interface swl_pins_if;
  logic [11:0] pins; // {port3[3:0], port2[7:0]}
  logic [11:0] ign; // pins the source-select level logic must disregard
  logic [11:0] outm; // pins configured as outputs
  logic [7:0] src_cfg; // stop_recovery_control
  logic [3:0] combo_cfg; // combo_wake_select
  modport drv (output pins, ign, outm, src_cfg, combo_cfg);
  modport src (input pins, ign, outm, src_cfg, combo_cfg);
endinterface

// >>> design/swl_change_det.sv
// change-detect wake source for one port
`timescale 1ns/1ps
module swl_change_det #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pins_in, // synchronised pins
  input wire logic [W-1:0] sel_in, // pins claimed as sources
  input wire logic [W-1:0] ref_in, // latched reference
  input wire logic [1:0] status_in, // latch status
  output logic ev_out // any selected pin active
);
  // without a latched reference a selected pin wakes on a zero
  always_comb begin
    if (status_in == swl_pkg::ST_NONE) begin
      ev_out = |(sel_in & ~pins_in);
    end else begin
      ev_out = |(sel_in & (pins_in ^ ref_in));
    end
  end
endmodule

// >>> design/swl_level_src.sv
// level-triggered wake sources: single pins and pin groups
`timescale 1ns/1ps
module swl_level_src (
  swl_pins_if.src pins, // pins and selections
  output logic src_ev_out, // stop_recovery_control source active
  output logic combo_ev_out // combo_wake_select source active
);
  // and of the usable pins in a group compared with the level
  function automatic logic grp_hit(input logic [11:0] v, input logic [11:0] ign,
                                   input logic [11:0] m, input logic lvl);
    logic [11:0] use_m;
    use_m = m & ~ign;
    grp_hit = (use_m != 12'h000) && ((&(v | ~use_m)) == lvl);
  endfunction

  // a group with every pin ignored never fires
  always_comb begin
    unique case (swl_pkg::swl_mode_e'(pins.src_cfg[swl_pkg::SRC_MODE_HI:swl_pkg::SRC_MODE_LO]))
      swl_pkg::MODE_NONE, swl_pkg::MODE_RSV: src_ev_out = 1'b0;
      swl_pkg::MODE_P31: src_ev_out = grp_hit(pins.pins, pins.ign, swl_pkg::M_P31, pins.src_cfg[swl_pkg::SRC_LVL]);
      swl_pkg::MODE_P32: src_ev_out = grp_hit(pins.pins, pins.ign, swl_pkg::M_P32, pins.src_cfg[swl_pkg::SRC_LVL]);
      swl_pkg::MODE_P33: src_ev_out = grp_hit(pins.pins, pins.ign, swl_pkg::M_P33, pins.src_cfg[swl_pkg::SRC_LVL]);
      swl_pkg::MODE_P2LO: src_ev_out = grp_hit(pins.pins, pins.ign, swl_pkg::M_P2LO, pins.src_cfg[swl_pkg::SRC_LVL]);
      swl_pkg::MODE_P2HI: src_ev_out = grp_hit(pins.pins, pins.ign, swl_pkg::M_P2HI, pins.src_cfg[swl_pkg::SRC_LVL]);
      swl_pkg::MODE_P2ALL: src_ev_out = grp_hit(pins.pins, pins.ign, swl_pkg::M_P2ALL, pins.src_cfg[swl_pkg::SRC_LVL]);
    endcase
  end

  // seven port 2 / port 3 combinations, outputs disregarded
  always_comb begin
    logic [11:0] m;
    m = 12'h000;
    unique case (pins.combo_cfg[2:0])
      3'h0: m = 12'h000;
      3'h1: m = 12'h101;
      3'h2: m = 12'h202;
      3'h3: m = 12'h404;
      3'h4: m = 12'h808;
      3'h5: m = 12'h303;
      3'h6: m = 12'hC0C;
      3'h7: m = 12'hFFF;
    endcase
    combo_ev_out = grp_hit(pins.pins, pins.outm, m, pins.combo_cfg[swl_pkg::COMBO_LVL]);
  end
endmodule

// >>> design/swl_wake_top.sv
// stop-mode wake and recovery logic with its register slave
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module swl_wake_top #(
  parameter int unsigned POR_CYCLES = swl_pkg::POR_CYC,
  parameter int unsigned SHORT_CYCLES = swl_pkg::SHORT_CYC
) (
  input wire logic clock_in, // 100 mhz clock
  input wire logic rst_n_in, // power-on class reset
  input wire logic [swl_pkg::AW-1:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [swl_pkg::DW-1:0] avs_writedata_in, // write data
  output logic [swl_pkg::DW-1:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // slave not ready
  input wire logic [7:0] p2_pins_in, // port 2 pins
  input wire logic [3:0] p3_pins_in, // port 3 pins
  input wire logic osc_ok_in, // crystal oscillation seen
  input wire logic stop_enter_in, // cpu executes stop
  output logic cpu_reset_out, // recovery reset to cpu
  output logic wake_irq_out, // routed wake interrupt
  output logic wake_p33_n_out, // routed wake on pin 3.3, low active
  output logic prescale_div16_out, // divide-by-16 enable
  output logic stopped_out // cpu held in stop
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  swl_pkg::swl_state_e state_ff;
  logic wait_ff;
  logic [swl_pkg::DW-1:0] rdata_ff;
  logic [7:0] src_ff;
  logic [7:0] p2cw_ff;
  logic [3:0] combo_ff;
  logic [3:0] p3cw_ff;
  logic [7:0] route_ff;
  logic [7:0] p2_ref_ff;
  logic [3:0] p3_ref_ff;
  logic [7:0] p2_dir_ff;
  logic [3:0] p3_dir_ff;
  logic [12:0] sync1_ff;
  logic [12:0] sync2_ff;
  logic [swl_pkg::CNT_W-1:0] cnt_ff;
  logic wake_ev_ff;
  logic cpu_rst_ff;
  logic irq_ff;
  logic p33_n_ff;
  logic stopped_ff;
  logic src_ev, combo_ev, p2_ev, p3_ev;
  logic req, acc, cap, rec_done;
  logic [7:0] p2_s;
  logic [3:0] p3_s;
  logic osc_s;
  logic [7:0] rd_mux;
  logic [swl_pkg::CNT_W-1:0] lim;

  swl_pins_if pif ();

  function automatic logic hit(input logic [swl_pkg::AW-1:0] a, input logic [13:0] idx);
    hit = (a[swl_pkg::AW-1:2] == idx);
  endfunction

  // pins arrive from outside; two stages before any use
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_ff <= 13'h0;
      sync2_ff <= 13'h0;
    end else begin
      sync1_ff <= {osc_ok_in, p3_pins_in, p2_pins_in};
      sync2_ff <= sync1_ff;
    end
  end
  assign p2_s = sync2_ff[7:0];
  assign p3_s = sync2_ff[11:8];
  assign osc_s = sync2_ff[12];

  // bus handshake: one wait state, then the request is taken
  assign req = avs_read_in | avs_write_in;
  assign acc = req & ~wait_ff;
  assign cap = avs_read_in & wait_ff;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= ~(req & wait_ff);
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = 8'h00;
    if (hit(avs_address_in, swl_pkg::IDX_SRC)) rd_mux = src_ff;
    if (hit(avs_address_in, swl_pkg::IDX_P2CW)) rd_mux = p2cw_ff;
    if (hit(avs_address_in, swl_pkg::IDX_COMBO)) rd_mux = {4'h0, combo_ff};
    if (hit(avs_address_in, swl_pkg::IDX_P3CW)) rd_mux = {4'h0, p3cw_ff};
    if (hit(avs_address_in, swl_pkg::IDX_ROUTE)) rd_mux = route_ff;
    if (hit(avs_address_in, swl_pkg::IDX_P2DAT)) rd_mux = p2_s;
    if (hit(avs_address_in, swl_pkg::IDX_P3DAT)) begin
      rd_mux = {4'h0, p3_s};
      if (route_ff[swl_pkg::RT_EN]) rd_mux[3] = ~wake_ev_ff;
    end
    if (hit(avs_address_in, swl_pkg::IDX_P2DIR)) rd_mux = p2_dir_ff;
    if (hit(avs_address_in, swl_pkg::IDX_P3DIR)) rd_mux = {4'h0, p3_dir_ff};
  end

  // read data captured with the wait-state edge so it stands when taken
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (cap) begin
      rdata_ff <= {24'h00_0000, rd_mux};
    end
  end

  // control register; recovery outranks a write in the same cycle
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_ff <= swl_pkg::SRC_RST;
    end else begin
      if (acc && avs_write_in && hit(avs_address_in, swl_pkg::IDX_SRC)) begin
        src_ff <= (src_ff & ~swl_pkg::SRC_WMASK) | (avs_writedata_in[7:0] & swl_pkg::SRC_WMASK);
      end
      if (state_ff == swl_pkg::ST_RECOVER && rec_done) begin
        src_ff[swl_pkg::SRC_FLAG] <= 1'b1;
        src_ff[swl_pkg::SRC_DIV] <= 1'b0;
      end
    end
  end

  // selection and direction registers keep their values across recovery
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      p2cw_ff <= 8'h00;
      combo_ff <= 4'h0;
      p3cw_ff <= 4'h0;
      p2_dir_ff <= 8'h00;
      p3_dir_ff <= 4'h0;
    end else if (acc && avs_write_in) begin
      if (hit(avs_address_in, swl_pkg::IDX_P2CW)) p2cw_ff <= avs_writedata_in[7:0];
      if (hit(avs_address_in, swl_pkg::IDX_COMBO)) combo_ff <= avs_writedata_in[3:0];
      if (hit(avs_address_in, swl_pkg::IDX_P3CW)) p3cw_ff <= avs_writedata_in[3:0];
      if (hit(avs_address_in, swl_pkg::IDX_P2DIR)) p2_dir_ff <= avs_writedata_in[7:0];
      if (hit(avs_address_in, swl_pkg::IDX_P3DIR)) p3_dir_ff <= avs_writedata_in[3:0];
    end
  end

  // reference latches: port read latches the pins, port write the data
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      p2_ref_ff <= 8'h00;
      p3_ref_ff <= 4'h0;
    end else begin
      if (p2cw_ff != 8'h00 && hit(avs_address_in, swl_pkg::IDX_P2DAT)) begin
        if (cap) p2_ref_ff <= p2_s;
        else if (acc && avs_write_in) p2_ref_ff <= avs_writedata_in[7:0];
      end
      if (p3cw_ff != 4'h0 && hit(avs_address_in, swl_pkg::IDX_P3DAT)) begin
        if (cap) p3_ref_ff <= p3_s;
        else if (acc && avs_write_in) p3_ref_ff <= avs_writedata_in[3:0];
      end
    end
  end

  // route status: hardware latch status wins over a software clear
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      route_ff <= 8'h00;
    end else begin
      if (acc && avs_write_in && hit(avs_address_in, swl_pkg::IDX_ROUTE)) begin
        route_ff <= {3'h0, avs_writedata_in[4:0]};
      end
      if (state_ff == swl_pkg::ST_RECOVER && rec_done) begin
        route_ff[3:0] <= 4'h0;
      end
      if (p2cw_ff != 8'h00 && hit(avs_address_in, swl_pkg::IDX_P2DAT)) begin
        if (cap) route_ff[1:0] <= swl_pkg::ST_READ;
        else if (acc && avs_write_in) route_ff[1:0] <= swl_pkg::ST_WRITE;
      end
      if (p3cw_ff != 4'h0 && hit(avs_address_in, swl_pkg::IDX_P3DAT)) begin
        if (cap) route_ff[3:2] <= swl_pkg::ST_READ;
        else if (acc && avs_write_in) route_ff[3:2] <= swl_pkg::ST_WRITE;
      end
    end
  end

  // source-select level logic sees only input pins not claimed by change detect; combination logic drops outputs only
  assign pif.pins = {p3_s, p2_s};
  assign pif.ign = {p3_dir_ff | p3cw_ff, p2_dir_ff | p2cw_ff};
  assign pif.outm = {p3_dir_ff, p2_dir_ff};
  assign pif.src_cfg = src_ff;
  assign pif.combo_cfg = combo_ff;

  swl_level_src u_level (
    .pins(pif.src),
    .src_ev_out(src_ev),
    .combo_ev_out(combo_ev)
  );

  swl_change_det #(.W(8)) u_p2 (
    .pins_in(p2_s & ~p2_dir_ff),
    .sel_in(p2cw_ff & ~p2_dir_ff),
    .ref_in(p2_ref_ff),
    .status_in(route_ff[1:0]),
    .ev_out(p2_ev)
  );

  swl_change_det #(.W(4)) u_p3 (
    .pins_in(p3_s & ~p3_dir_ff),
    .sel_in(p3cw_ff & ~p3_dir_ff),
    .ref_in(p3_ref_ff),
    .status_in(route_ff[3:2]),
    .ev_out(p3_ev)
  );

  // wake event and routing; detection runs in every state
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_ev_ff <= 1'b0;
      irq_ff <= 1'b0;
      p33_n_ff <= 1'b1;
    end else begin
      wake_ev_ff <= src_ev | combo_ev | p2_ev | p3_ev;
      irq_ff <= route_ff[swl_pkg::RT_EN] & wake_ev_ff;
      p33_n_ff <= ~(route_ff[swl_pkg::RT_EN] & wake_ev_ff);
    end
  end

  // delay limit: full por period, or a short one after oscillation
  assign lim = src_ff[swl_pkg::SRC_SHORT] ? swl_pkg::CNT_W'(SHORT_CYCLES) : swl_pkg::CNT_W'(POR_CYCLES);
  assign rec_done = !src_ff[swl_pkg::SRC_DLY] || (cnt_ff >= lim);

  // stop / recovery sequencer
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= swl_pkg::ST_RUN;
      cnt_ff <= '0;
      cpu_rst_ff <= 1'b0;
      stopped_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        swl_pkg::ST_RUN: begin
          if (stop_enter_in) begin
            state_ff <= swl_pkg::ST_STOPPED;
            stopped_ff <= 1'b1;
          end
        end
        swl_pkg::ST_STOPPED: begin
          if (wake_ev_ff) begin
            state_ff <= swl_pkg::ST_RECOVER;
            stopped_ff <= 1'b0;
            cnt_ff <= '0;
            cpu_rst_ff <= 1'b1;
          end
        end
        swl_pkg::ST_RECOVER: begin
          if (rec_done) begin
            state_ff <= swl_pkg::ST_RUN;
            cpu_rst_ff <= 1'b0;
          end else if (!src_ff[swl_pkg::SRC_SHORT] || osc_s) begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
      endcase
    end
  end

  // all outputs straight from flip-flops
  assign avs_readdata_out = rdata_ff;
  assign avs_waitrequest_out = wait_ff;
  assign cpu_reset_out = cpu_rst_ff;
  assign wake_irq_out = irq_ff;
  assign wake_p33_n_out = p33_n_ff;
  assign prescale_div16_out = src_ff[swl_pkg::SRC_DIV];
  assign stopped_out = stopped_ff;

  a_flag_write_ignored: assert property (
    (acc && avs_write_in && hit(avs_address_in, swl_pkg::IDX_SRC) && state_ff != swl_pkg::ST_RECOVER)
    |=> $stable(src_ff[swl_pkg::SRC_FLAG])) else $error("stop flag changed by a write");

  a_recovery_sets_flag: assert property (
    (state_ff == swl_pkg::ST_RECOVER && rec_done) |=> src_ff[swl_pkg::SRC_FLAG] && state_ff == swl_pkg::ST_RUN)
    else $error("recovery did not set stop flag");

  a_recovery_clears_div: assert property (
    (state_ff == swl_pkg::ST_RECOVER && rec_done) |=> !prescale_div16_out)
    else $error("divider bit survived recovery");

  a_bypass_one_cycle: assert property (
    (state_ff == swl_pkg::ST_STOPPED && wake_ev_ff && !src_ff[swl_pkg::SRC_DLY])
    |=> cpu_reset_out ##1 (!cpu_reset_out && state_ff == swl_pkg::ST_RUN))
    else $error("bypassed recovery not one cycle");

  a_delay_holds_reset: assert property (
    (state_ff == swl_pkg::ST_RECOVER && src_ff[swl_pkg::SRC_DLY] && cnt_ff < lim) |-> cpu_reset_out)
    else $error("cpu reset released before delay end");

  a_route_irq: assert property (
    (route_ff[swl_pkg::RT_EN] && wake_ev_ff) |=> wake_irq_out && !wake_p33_n_out)
    else $error("routed wake not signalled");

  a_no_route_irq: assert property (
    !route_ff[swl_pkg::RT_EN] |=> !wake_irq_out) else $error("interrupt raised without routing");

  a_reserved_mode: assert property (
    (src_ff[swl_pkg::SRC_MODE_HI:swl_pkg::SRC_MODE_LO] <= 3'h1) |-> !src_ev)
    else $error("reserved mode raised event");

  a_any_source_wakes: assert property (
    (src_ev || combo_ev || p2_ev || p3_ev) |=> wake_ev_ff) else $error("source active but no wake event");

  a_p2_write_ref: assert property (
    (acc && avs_write_in && hit(avs_address_in, swl_pkg::IDX_P2DAT) && p2cw_ff != 8'h00)
    |=> p2_ref_ff == $past(avs_writedata_in[7:0]) && route_ff[1:0] == swl_pkg::ST_WRITE)
    else $error("port 2 write reference not latched");

  a_p3_read_ref: assert property (
    (cap && hit(avs_address_in, swl_pkg::IDX_P3DAT) && p3cw_ff != 4'h0)
    |=> p3_ref_ff == $past(p3_s) && route_ff[3:2] == swl_pkg::ST_READ)
    else $error("port 3 read reference not latched");

  a_short_waits_osc: assert property (
    (state_ff == swl_pkg::ST_RECOVER && !rec_done && src_ff[swl_pkg::SRC_SHORT] && !osc_s)
    |=> $stable(cnt_ff)) else $error("short delay counted without oscillation");
endmodule

// >>> tb/swl_pin_model.sv
// partner model of the port pins and crystal feeding the wake logic
`timescale 1ns/1ps
module swl_pin_model (
  input wire logic clock_in, // bench clock
  input wire logic [11:0] want_in, // requested {p3, p2} levels
  output logic [7:0] p2_out, // port 2 pins
  output logic [3:0] p3_out, // port 3 pins
  output logic osc_out // crystal oscillation seen
);
  logic [11:0] lvl = 12'hFFF;
  int hold = 0;
  int age = 0;
  // pins only change on a clock edge, never mid-cycle
  assign {p3_out, p2_out} = lvl;
  // crystal settles a few clocks after start and then runs
  assign osc_out = (age > 4);
  // a new level waits until the last one stood 10 clocks
  always @(posedge clock_in) begin
    age <= age + 1;
    hold <= (want_in != lvl && hold >= 10) ? 0 : hold + 1;
    if (want_in != lvl && hold >= 10) lvl <= want_in;
  end
endmodule

// >>> tb/tb_stop_mode_wake_logic.sv
// self-checking bench of the stop-mode wake logic
`timescale 1ns/1ps
module tb_stop_mode_wake_logic;
  localparam int unsigned PORC = 20;
  localparam int unsigned SHC = 8;
  logic clock_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic [15:0] avs_address_in = 16'h0000;
  logic avs_read_in = 1'h0;
  logic avs_write_in = 1'h0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, cpu_reset_out, wake_irq_out, wake_p33_n_out, prescale_div16_out, stopped_out;
  logic stop_enter_in = 1'h0;
  logic [7:0] p2_pins_in;
  logic [3:0] p3_pins_in;
  logic osc_ok_in;
  logic [11:0] want = 12'hFFF;
  logic [31:0] q;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  // 100 mhz clock
  always #5 clock_in = ~clock_in;
  swl_wake_top #(.POR_CYCLES(PORC), .SHORT_CYCLES(SHC)) i_dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .p2_pins_in(p2_pins_in), .p3_pins_in(p3_pins_in), .osc_ok_in(osc_ok_in),
    .stop_enter_in(stop_enter_in), .cpu_reset_out(cpu_reset_out), .wake_irq_out(wake_irq_out),
    .wake_p33_n_out(wake_p33_n_out), .prescale_div16_out(prescale_div16_out), .stopped_out(stopped_out));
  swl_pin_model i_pins (.clock_in(clock_in), .want_in(want), .p2_out(p2_pins_in), .p3_out(p3_pins_in),
    .osc_out(osc_ok_in));
  // shared compare, counts every call
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  // one avalon cycle; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d);
    @(posedge clock_in);
    avs_address_in <= {idx, 2'h0};
    avs_write_in <= w;
    avs_read_in <= ~w;
    avs_writedata_in <= {24'h000000, d};
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'h0) @(posedge clock_in);
    q = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
  endtask
  // power-on class reset, 4 clocks
  task automatic por();
    @(posedge clock_in);
    rst_n_in <= 1'h0;
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'h1;
  endtask
  // enter stop, move the pins, measure the recovery reset width in n
  task automatic stop_wake(input logic [11:0] pins);
    @(posedge clock_in);
    stop_enter_in <= 1'h1;
    @(posedge clock_in);
    stop_enter_in <= 1'h0;
    @(posedge clock_in);
    chk("stopped", stopped_out, 32'h1);
    want <= pins;
    n = 0;
    for (int i = 0; i < 60 && cpu_reset_out !== 1'h1; i++) @(posedge clock_in);
    while (cpu_reset_out === 1'h1 && n < 500) begin
      @(posedge clock_in);
      n++;
    end
  endtask
  // reset values, read-only flag, unmapped address
  task automatic t_regs();
    chk("wait idle", avs_waitrequest_out, 32'h1);
    bus(1'h0, swl_pkg::IDX_SRC, 8'h00);
    chk("src reset", q, 32'h20);
    bus(1'h0, swl_pkg::IDX_ROUTE, 8'h00);
    chk("route reset", q, 32'h0);
    bus(1'h1, swl_pkg::IDX_SRC, 8'hFF);
    bus(1'h0, swl_pkg::IDX_SRC, 8'h00);
    chk("src flag write", q, 32'h7F);
    chk("div16", prescale_div16_out, 32'h1);
    bus(1'h0, 14'h0100, 8'h00);
    chk("unmapped", q, 32'h0);
  endtask
  // bypassed delay: wake on high p3.1, one-cycle reset, flag set
  task automatic t_bypass();
    want <= 12'hDFF;
    bus(1'h1, swl_pkg::IDX_SRC, 8'h49);
    repeat (20) @(posedge clock_in);
    stop_wake(12'hFFF);
    chk("bypass width", n, 32'h1);
    bus(1'h0, swl_pkg::IDX_SRC, 8'h00);
    chk("src after wake", q, 32'hC8);
  endtask
  // long and short wake delay on low p3.2, routed to irq and pin
  task automatic t_delay();
    bus(1'h1, swl_pkg::IDX_ROUTE, 8'h10);
    for (int b = 0; b < 2; b++) begin
      want <= 12'hFFF;
      bus(1'h1, swl_pkg::IDX_SRC, b ? 8'h2E : 8'h2C);
      repeat (20) @(posedge clock_in);
      stop_wake(12'hBFF);
      chk("delay width", n, b ? SHC + 1 : PORC + 1);
    end
    chk("irq", wake_irq_out, 32'h1);
    chk("p33", wake_p33_n_out, 32'h0);
    bus(1'h0, swl_pkg::IDX_P3DAT, 8'h00);
    chk("p3 bit3", q[3], 32'h0);
    bus(1'h0, swl_pkg::IDX_ROUTE, 8'h00);
    chk("route kept", q, 32'h10);
  endtask
  // modes 000, 001 and output pin p3.1, held low below its high wake level, raise no wake
  task automatic t_none();
    for (int m = 0; m < 3; m++) begin
      por();
      want <= 12'hDFF;
      if (m == 2) bus(1'h1, swl_pkg::IDX_P3DIR, 8'h02);
      bus(1'h1, swl_pkg::IDX_SRC, m == 2 ? 8'h48 : 8'h40 | 8'(m << 2));
      repeat (20) @(posedge clock_in);
      stop_wake(12'h000);
      chk("no wake", n, 32'h0);
    end
    por();
    bus(1'h0, swl_pkg::IDX_SRC, 8'h00);
    chk("src por", q, 32'h20);
  endtask
  // change detect: port 2 reference by write, port 3 by read
  task automatic t_change();
    want <= 12'hEFE;
    bus(1'h1, swl_pkg::IDX_P2CW, 8'h01);
    bus(1'h1, swl_pkg::IDX_P2DAT, 8'h00);
    bus(1'h1, swl_pkg::IDX_SRC, 8'h00);
    repeat (20) @(posedge clock_in);
    bus(1'h0, swl_pkg::IDX_ROUTE, 8'h00);
    chk("p2 latch", q, 32'h2);
    stop_wake(12'hEFF);
    chk("p2 change", n, 32'h1);
    bus(1'h1, swl_pkg::IDX_P3CW, 8'h01);
    bus(1'h0, swl_pkg::IDX_P3DAT, 8'h00);
    bus(1'h0, swl_pkg::IDX_ROUTE, 8'h00);
    chk("p3 latch", q, 32'h4);
    stop_wake(12'hFFF);
    chk("p3 change", n, 32'h1);
  endtask
  // combination p2.3 and p3.3 high wakes; a claimed pin is ignored
  task automatic t_combo();
    por();
    want <= 12'h7F7;
    bus(1'h1, swl_pkg::IDX_COMBO, 8'h0C);
    bus(1'h1, swl_pkg::IDX_SRC, 8'h00);
    repeat (20) @(posedge clock_in);
    stop_wake(12'hFF7);
    chk("combo one pin", n, 32'h0);
    stop_wake(12'hFFF);
    chk("combo both pins", n, 32'h1);
    bus(1'h1, swl_pkg::IDX_COMBO, 8'h00);
    bus(1'h1, swl_pkg::IDX_P3CW, 8'h02);
    bus(1'h1, swl_pkg::IDX_SRC, 8'h48);
    stop_wake(12'hFFF);
    chk("claimed pin", n, 32'h0);
  endtask
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog well beyond the several hundred clocks the run needs
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'h1;
    t_regs();
    t_bypass();
    t_delay();
    t_none();
    t_change();
    t_combo();
    final_report();
  end
endmodule
